//--- verification/crs_core_regs_asserts.sv
// Concurrent checks on the ports of the core register set
`timescale 1ns/100ps
`default_nettype none
module crs_core_regs_asserts #(
  parameter int unsigned PC_WIDTH = 16
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic [1:0]          pc_op,
  input wire logic [1:0]          pc_len,
  input wire logic                ea_req,
  input wire logic [7:0]          ea_operand,
  input wire logic [3:0]          sp_op,
  input wire logic                alu_we,
  input wire logic [7:0]          alu_result,
  input wire logic                upd_zero,
  input wire logic [1:0]          flag_op,
  input wire logic                sup_enter,
  input wire logic                sup_exit,
  input wire logic                irq_req,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata_ff,
  input wire logic [PC_WIDTH-1:0] program_counter_ff,
  input wire logic [7:0]          idx_ff,
  input wire logic [7:0]          stack_pointer_reg_ff,
  input wire logic [7:0]          flags_ff,
  input wire logic                bank_select_flag_ff,
  input wire logic                global_interrupt_enable_ff,
  input wire logic [8:0]          ea_ff,
  input wire logic                irq_take_ff
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  pc_step_a: assert property (pc_op == 2'b01 |=> program_counter_ff ==
    $past(program_counter_ff) + PC_WIDTH'($past(pc_len))) else $error("pc step wrong");
  ea_index_a: assert property (ea_req |=> ea_ff[7:0] == 8'($past(idx_ff) + $past(ea_operand)))
    else $error("indexed address wrong");
  sp_push_a: assert property (sp_op == 4'h1 |=> stack_pointer_reg_ff == $past(stack_pointer_reg_ff) + 8'h01)
    else $error("push step wrong");
  super_hold_a: assert property (!sup_enter && !sup_exit |=> $stable(flags_ff[3]))
    else $error("super bit moved");
  flag_copy_a: assert property (bank_select_flag_ff == flags_ff[4] &&
    global_interrupt_enable_ff == flags_ff[0]) else $error("flag copies differ");
  irq_gate_a: assert property (!global_interrupt_enable_ff |=> !irq_take_ff)
    else $error("irq taken while disabled");
  irq_take_a: assert property (irq_req && global_interrupt_enable_ff |=> irq_take_ff)
    else $error("irq not taken");
  zero_flag_a: assert property (alu_we && upd_zero && flag_op == 2'b00 |=>
    flags_ff[1] == ($past(alu_result) == 8'h00)) else $error("zero flag wrong");
  rd_flags_a: assert property (reg_rd && reg_addr == 8'hf7 |=> reg_rdata_ff == ($past(flags_ff) & 8'h1f))
    else $error("flags read wrong");
  rd_other_a: assert property (!(reg_rd && reg_addr == 8'hf7) |=> reg_rdata_ff == 8'h00)
    else $error("read data not idle");
  rsvd_zero_a: assert property (flags_ff[7:5] == 3'b000)
    else $error("reserved flag bits set");

  cover property (reg_rd && reg_addr == 8'hf7);
  cover property (irq_take_ff);
  cover property (sp_op == 4'h6);
endmodule

bind crs_core_regs crs_core_regs_asserts #(.PC_WIDTH(PC_WIDTH)) i_crs_core_regs_asserts (
  .mclk(mclk), .rst_n(rst_n), .pc_op(pc_op), .pc_len(pc_len), .ea_req(ea_req), .ea_operand(ea_operand),
  .sp_op(sp_op), .alu_we(alu_we), .alu_result(alu_result), .upd_zero(upd_zero), .flag_op(flag_op),
  .sup_enter(sup_enter), .sup_exit(sup_exit), .irq_req(irq_req), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .program_counter_ff(program_counter_ff), .idx_ff(idx_ff),
  .stack_pointer_reg_ff(stack_pointer_reg_ff), .flags_ff(flags_ff), .bank_select_flag_ff(bank_select_flag_ff),
  .global_interrupt_enable_ff(global_interrupt_enable_ff), .ea_ff(ea_ff), .irq_take_ff(irq_take_ff));
`default_nettype wire

//--- verification/tb_crs_core_regs.sv
// Self-checking bench for the core register set
`timescale 1ns/100ps
`default_nettype none
module tb_crs_core_regs;
  typedef struct packed {
    logic [15:0] pc_load_val, pc_rel_off;
    logic [7:0]  acc_wdata, idx_wdata, ea_operand, sp_imm, alu_result, flag_imm, reg_addr, reg_wdata;
    logic [3:0]  sp_op;
    logic [1:0]  pc_op, pc_len, flag_op;
    logic        acc_we, idx_we, ea_req, ea_reg_space, alu_we, alu_carry, upd_zero, upd_carry;
    logic        sup_enter, sup_exit, irq_req, reg_wr, reg_rd;
  } crs_stim_s;

  logic        mclk;
  logic        rst_n;
  crs_stim_s   d;
  crs_stim_s   v;
  logic [15:0] pc, e_pc;
  logic [7:0]  rdata, acc, idx, sp, fl, e_rd, e_acc, e_idx, e_sp, e_fl;
  logic [8:0]  ea, e_ea;
  logic        bank, gie, irq, e_irq;
  logic [7:0]  addrs [5] = '{8'hf7, 8'hf6, 8'hf7, 8'hf7, 8'h00};
  int          num_errors;
  int          num_checks;

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  crs_core_regs i_crs_core_regs (
    .mclk(mclk), .rst_n(rst_n), .pc_op(d.pc_op), .pc_len(d.pc_len), .pc_load_val(d.pc_load_val),
    .pc_rel_off(d.pc_rel_off), .acc_we(d.acc_we), .acc_wdata(d.acc_wdata), .idx_we(d.idx_we),
    .idx_wdata(d.idx_wdata), .ea_req(d.ea_req), .ea_operand(d.ea_operand), .ea_reg_space(d.ea_reg_space),
    .sp_op(d.sp_op), .sp_imm(d.sp_imm), .alu_we(d.alu_we), .alu_result(d.alu_result),
    .alu_carry(d.alu_carry), .upd_zero(d.upd_zero), .upd_carry(d.upd_carry), .flag_op(d.flag_op),
    .flag_imm(d.flag_imm), .sup_enter(d.sup_enter), .sup_exit(d.sup_exit), .irq_req(d.irq_req),
    .reg_addr(d.reg_addr), .reg_wdata(d.reg_wdata), .reg_wr(d.reg_wr), .reg_rd(d.reg_rd),
    .reg_rdata_ff(rdata), .program_counter_ff(pc), .acc_ff(acc), .idx_ff(idx), .stack_pointer_reg_ff(sp),
    .flags_ff(fl), .bank_select_flag_ff(bank), .global_interrupt_enable_ff(gie), .ea_ff(ea),
    .irq_take_ff(irq));

  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_all();
    chk(pc, e_pc, "pc");
    chk(16'(acc), 16'(e_acc), "acc");
    chk(16'(idx), 16'(e_idx), "idx");
    chk(16'(ea), 16'(e_ea), "ea");
    chk(16'(sp), 16'(e_sp), "sp");
    chk(16'(fl), 16'(e_fl), "flags");
    chk(16'({bank, gie}), 16'({e_fl[4], e_fl[0]}), "bank gie");
    chk(16'(irq), 16'(e_irq), "irq take");
    chk(16'(rdata), 16'(e_rd), "read data");
  endtask

  // Next state from the inputs now held; swap uses values from before the edge
  task automatic model();
    logic [7:0] f;
    logic [7:0] a;
    f = e_fl;
    a = e_acc;
    e_rd = (d.reg_rd && d.reg_addr == 8'hf7) ? f : 8'h00;
    e_irq = d.irq_req & f[0];
    case (d.pc_op)
      2'b01: e_pc = e_pc + 16'(d.pc_len);
      2'b10: e_pc = d.pc_load_val;
      2'b11: e_pc = e_pc + d.pc_rel_off;
      default: ;
    endcase
    if (d.ea_req) e_ea = {d.ea_reg_space & f[4], 8'(e_idx + d.ea_operand)};
    if (d.idx_we) e_idx = d.idx_wdata;
    if (d.acc_we) e_acc = d.acc_wdata;
    case (d.sp_op)
      4'h1: e_sp = e_sp + 8'h01;
      4'h2: e_sp = e_sp - 8'h01;
      4'h3, 4'h4: e_sp = e_sp + 8'h02;
      4'h5: e_sp = e_sp - 8'h02;
      4'h6: e_sp = e_sp - 8'h03;
      4'h7: begin
        e_acc = e_sp;
        e_sp = a;
      end
      4'h8: e_sp = e_sp + d.sp_imm;
      default: ;
    endcase
    case (d.flag_op)
      2'b01: f = f & (d.flag_imm | 8'he8);
      2'b10: f = f | (d.flag_imm & 8'h17);
      2'b11: f = f ^ (d.flag_imm & 8'h17);
      default: begin
        if (d.alu_we && d.upd_zero) f[1] = (d.alu_result == 8'h00);
        if (d.alu_we && d.upd_carry) f[2] = d.alu_carry;
      end
    endcase
    if (d.sup_enter) f[3] = 1'b1;
    else if (d.sup_exit) f[3] = 1'b0;
    e_fl = f;
  endtask

  task automatic tick(input crs_stim_s s);
    @(posedge mclk);
    d <= s;
    #1;
    check_all();
    model();
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    d <= '0;
    {e_pc, e_acc, e_idx, e_sp, e_ea, e_irq, e_rd} = '0;
    e_fl = 8'h02;
    #1;
    check_all();
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  // Flag logic rarely, zero results often, reads mostly of the flags place
  function automatic crs_stim_s rnd();
    crs_stim_s r;
    r = crs_stim_s'(119'({$urandom, $urandom, $urandom, $urandom}));
    if (r.reg_rd) r.reg_wr = 1'b0;
    if ($urandom_range(0, 1) == 0) r.reg_addr = 8'hf7;
    if ($urandom_range(0, 3) != 0) r.flag_op = 2'b00;
    if ($urandom_range(0, 2) == 0) r.alu_result = 8'h00;
    return r;
  endfunction

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    d = '0;
    void'($urandom(86738));
    do_reset();
    foreach (addrs[k]) begin
      v = '0;
      v.reg_rd = (k != 2);
      v.reg_wr = (k == 2);
      v.reg_wdata = 8'hff;
      v.reg_addr = addrs[k];
      tick(v);
    end
    for (int i = 0; i < 16; i++) begin
      v = '0;
      v.sp_op = 4'(i);
      v.sp_imm = 8'h81;
      v.acc_we = 1'b1;
      v.acc_wdata = 8'(8'h40 + i);
      v.pc_op = 2'(i);
      v.pc_len = 2'(i + 1);
      v.pc_load_val = 16'hfffe;
      v.pc_rel_off = 16'hfff0;
      tick(v);
    end
    // Every flag code, with an ALU result in the same cycle that loses to codes 1 to 3
    for (int i = 0; i < 8; i++) begin
      v = '0;
      v.flag_op = 2'(i % 4);
      v.flag_imm = (i < 4) ? 8'hff : 8'h15;
      {v.irq_req, v.alu_we, v.upd_zero, v.upd_carry} = 4'hf;
      v.alu_carry = i[0];
      v.alu_result = 8'(i & 2);
      v.sup_enter = (i == 5);
      v.sup_exit = (i >= 5);
      {v.ea_req, v.ea_reg_space, v.idx_we} = 3'b111;
      v.ea_operand = 8'hff;
      v.idx_wdata = 8'(i * 37);
      v.reg_rd = 1'b1;
      v.reg_addr = 8'hf7;
      tick(v);
    end
    repeat (3000) tick(rnd());
    do_reset();
    repeat (2000) tick(rnd());
    finish_test();
  end
endmodule
`default_nettype wire

//--- verilog/crs_adder.sv
// Plain parameterised adder used for address and pointer arithmetic
`timescale 1ns/100ps
`default_nettype none
module crs_adder #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  output logic      [WIDTH-1:0] sum,
  output logic                  carry
);

  logic [WIDTH:0] full;

  if (WIDTH < 1) begin : g_chk
    $error("crs_adder needs a width of at least one");
  end

  always_comb begin
    full  = {1'b0, a} + {1'b0, b};
    sum   = full[WIDTH-1:0];
    carry = full[WIDTH];
  end

endmodule
`default_nettype wire

//--- verilog/crs_core_regs.sv
// Architectural register set of the 8-bit core: PC, accumulator, index, stack pointer, flags
//
// Behaviour
// (RQ1) A 16-bit program counter reaches all of program memory without paging.
// (RQ2) The accumulator takes the result of every source-addressing-mode instruction.
// (RQ3) The index register adds its value to the operand forming indexed addresses.
// (RQ4) Stack pointer tracks top of stack; push, pop, calls and returns move it.
// (RQ5) Swap and add instructions may also write the stack pointer.
// (RQ6) Flags: enable bit 0, zero bit 1, carry bit 2, supervisory bit 3.
// (RQ7) Supervisory bit is read-only to user code: 0 user, 1 supervisor.
// (RQ8) Arithmetic, logic and shift operations update flags per instruction.
// (RQ9) Flags are written only by logical AND, OR, XOR instructions on them.
// (RQ10) Bit 4 is user-writable and selects register bank 0 or 1.
// (RQ11) Carry flag reports carry from the preceding arithmetic or logic operation.
// (RQ12) Global interrupt enable gates all interrupts; none taken while clear.
// (RQ13) Core registers change only through instructions, never as register-space locations.
// (RQ14) Zero flag is 1 when the preceding result is zero, else 0.
// (RQ15) Flags register reads back at its fixed register-space address.
// (RQ16) Reserved flag bits 7 to 5 read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
module crs_core_regs #(
  parameter int unsigned PC_WIDTH = crs_pkg::PC_W
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Program counter control
  input  wire logic [1:0]           pc_op,
  input  wire logic [1:0]           pc_len,
  input  wire logic [PC_WIDTH-1:0]  pc_load_val,
  input  wire logic [PC_WIDTH-1:0]  pc_rel_off,
  // Accumulator and index writes
  input  wire logic                 acc_we,
  input  wire logic [7:0]           acc_wdata,
  input  wire logic                 idx_we,
  input  wire logic [7:0]           idx_wdata,
  // Indexed effective address request
  input  wire logic                 ea_req,
  input  wire logic [7:0]           ea_operand,
  input  wire logic                 ea_reg_space,
  // Stack pointer control
  input  wire logic [3:0]           sp_op,
  input  wire logic [7:0]           sp_imm,
  // ALU flag results
  input  wire logic                 alu_we,
  input  wire logic [7:0]           alu_result,
  input  wire logic                 alu_carry,
  input  wire logic                 upd_zero,
  input  wire logic                 upd_carry,
  // Logical instruction on the flags
  input  wire logic [1:0]           flag_op,
  input  wire logic [7:0]           flag_imm,
  // Supervisor entry and exit from the sequencer
  input  wire logic                 sup_enter,
  input  wire logic                 sup_exit,
  // Interrupt request from the interrupt controller
  input  wire logic                 irq_req,
  // Register space port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata_ff,
  // Register state
  output logic      [PC_WIDTH-1:0]  program_counter_ff,
  output logic      [7:0]           acc_ff,
  output logic      [7:0]           idx_ff,
  output logic      [7:0]           stack_pointer_reg_ff,
  output logic      [7:0]           flags_ff,
  output logic                      bank_select_flag_ff,
  output logic                      global_interrupt_enable_ff,
  output logic      [8:0]           ea_ff,
  output logic                      irq_take_ff
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (PC_WIDTH < crs_pkg::PC_MIN_W || PC_WIDTH > crs_pkg::PC_W) begin : g_chk
    $error("crs_core_regs: PC_WIDTH must cover program memory and fit the core");
  end

  // ****************************************
  // Declarations
  // ****************************************
  logic [PC_WIDTH-1:0] nxt_program_counter;
  logic [PC_WIDTH-1:0] pc_addend;
  logic [PC_WIDTH-1:0] pc_sum;
  logic [7:0]          nxt_acc;
  logic [7:0]          nxt_idx;
  logic [7:0]          nxt_stack_pointer;
  logic [7:0]          sp_addend;
  logic [7:0]          sp_sum;
  logic [7:0]          ea_sum;
  logic [8:0]          nxt_ea;
  logic [7:0]          flags_user_nxt;
  logic [7:0]          nxt_flags;
  logic                nxt_super;
  logic                super_ff;
  logic [7:0]          flags_view;
  logic [7:0]          nxt_reg_rdata;
  logic                unused_bus;

  // Writes to the flags address are dropped on purpose; the only write path is the flag logic
  assign unused_bus = reg_wr ^ (|reg_wdata); // RQ9 RQ13

  // ****************************************
  // Program counter
  // ****************************************
  always_comb begin
    pc_addend = {{(PC_WIDTH-2){1'b0}}, pc_len};
    if (pc_op == crs_pkg::CRS_PC_REL) begin
      pc_addend = pc_rel_off;
    end
  end

  crs_adder #(
    .WIDTH (PC_WIDTH)
  ) u_pc_add (
    .a     (program_counter_ff),
    .b     (pc_addend),
    .sum   (pc_sum),
    .carry ()
  );

  always_comb begin
    case (pc_op)
      crs_pkg::CRS_PC_HOLD: nxt_program_counter = program_counter_ff;
      crs_pkg::CRS_PC_STEP: nxt_program_counter = pc_sum; // RQ1
      crs_pkg::CRS_PC_LOAD: nxt_program_counter = pc_load_val; // RQ1
      crs_pkg::CRS_PC_REL:  nxt_program_counter = pc_sum; // RQ1
      default:              nxt_program_counter = program_counter_ff;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter_ff <= crs_pkg::PC_RESET[PC_WIDTH-1:0];
    end else begin
      program_counter_ff <= nxt_program_counter;
    end
  end

  // ****************************************
  // Accumulator
  // ****************************************
  always_comb begin
    nxt_acc = acc_ff;
    if (sp_op == crs_pkg::CRS_SP_SWAP) begin
      // Swap hands the old pointer to the accumulator in the same edge
      nxt_acc = stack_pointer_reg_ff; // RQ5
    end else if (acc_we) begin
      nxt_acc = acc_wdata; // RQ2
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= crs_pkg::ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // ****************************************
  // Index register and effective address
  // ****************************************
  always_comb begin
    nxt_idx = idx_ff;
    if (idx_we) begin
      nxt_idx = idx_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_ff <= crs_pkg::IDX_RESET;
    end else begin
      idx_ff <= nxt_idx;
    end
  end

  crs_adder #(
    .WIDTH (8)
  ) u_ea_add (
    .a     (idx_ff),
    .b     (ea_operand),
    .sum   (ea_sum),
    .carry ()
  );

  // Data memory addresses wrap at 256; register space takes the bank bit on top
  always_comb begin
    nxt_ea = ea_ff;
    if (ea_req) begin
      nxt_ea = {ea_reg_space & bank_select_flag_ff, ea_sum}; // RQ3 RQ10
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ea_ff <= crs_pkg::EA_RESET;
    end else begin
      ea_ff <= nxt_ea;
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  always_comb begin
    case (sp_op)
      crs_pkg::CRS_SP_PUSH:  sp_addend = crs_pkg::SP_STEP_PUSH; // RQ4
      crs_pkg::CRS_SP_POP:   sp_addend = crs_pkg::SP_STEP_POP; // RQ4
      crs_pkg::CRS_SP_CALL:  sp_addend = crs_pkg::SP_STEP_CALL; // RQ4
      crs_pkg::CRS_SP_LCALL: sp_addend = crs_pkg::SP_STEP_CALL; // RQ4
      crs_pkg::CRS_SP_RET:   sp_addend = crs_pkg::SP_STEP_RET; // RQ4
      crs_pkg::CRS_SP_RETI:  sp_addend = crs_pkg::SP_STEP_RETI; // RQ4
      crs_pkg::CRS_SP_ADD:   sp_addend = sp_imm; // RQ5
      default:               sp_addend = crs_pkg::SP_STEP_NONE;
    endcase
  end

  crs_adder #(
    .WIDTH (8)
  ) u_sp_add (
    .a     (stack_pointer_reg_ff),
    .b     (sp_addend),
    .sum   (sp_sum),
    .carry ()
  );

  always_comb begin
    case (sp_op)
      crs_pkg::CRS_SP_NONE: nxt_stack_pointer = stack_pointer_reg_ff;
      crs_pkg::CRS_SP_SWAP: nxt_stack_pointer = acc_ff; // RQ5
      crs_pkg::CRS_SP_PUSH,
      crs_pkg::CRS_SP_POP,
      crs_pkg::CRS_SP_CALL,
      crs_pkg::CRS_SP_LCALL,
      crs_pkg::CRS_SP_RET,
      crs_pkg::CRS_SP_RETI,
      crs_pkg::CRS_SP_ADD:  nxt_stack_pointer = sp_sum; // RQ4
      default:              nxt_stack_pointer = stack_pointer_reg_ff;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_reg_ff <= crs_pkg::SP_RESET;
    end else begin
      stack_pointer_reg_ff <= nxt_stack_pointer;
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  crs_flag_update u_flags (
    .flags_cur  (flags_ff),
    .alu_we     (alu_we),
    .alu_result (alu_result),
    .alu_carry  (alu_carry),
    .upd_zero   (upd_zero),
    .upd_carry  (upd_carry),
    .logic_op   (flag_op),
    .logic_imm  (flag_imm),
    .flags_nxt  (flags_user_nxt)
  );

  // Entry into supervisor code wins over a return in the same cycle
  always_comb begin
    nxt_super = super_ff;
    if (sup_enter) begin
      nxt_super = 1'b1; // RQ7
    end else if (sup_exit) begin
      nxt_super = 1'b0; // RQ7
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      super_ff <= crs_pkg::FLAGS_RESET[crs_pkg::FLAG_SUPER];
    end else begin
      super_ff <= nxt_super;
    end
  end

  always_comb begin
    nxt_flags                     = flags_user_nxt & crs_pkg::FLAGS_WMASK; // RQ16
    nxt_flags[crs_pkg::FLAG_SUPER] = nxt_super; // RQ6 RQ7
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= crs_pkg::FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags; // RQ8
    end
  end

  // Separate copies keep every output on its own flip-flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_select_flag_ff        <= crs_pkg::FLAGS_RESET[crs_pkg::FLAG_BANK];
      global_interrupt_enable_ff <= crs_pkg::FLAGS_RESET[crs_pkg::FLAG_GIE];
    end else begin
      bank_select_flag_ff        <= nxt_flags[crs_pkg::FLAG_BANK]; // RQ10
      global_interrupt_enable_ff <= nxt_flags[crs_pkg::FLAG_GIE]; // RQ6
    end
  end

  // ****************************************
  // Interrupt gate
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_take_ff <= 1'b0;
    end else begin
      irq_take_ff <= irq_req & flags_ff[crs_pkg::FLAG_GIE]; // RQ12
    end
  end

  // ****************************************
  // Register space read port
  // ****************************************
  always_comb begin
    flags_view = flags_ff & (crs_pkg::FLAGS_WMASK | (8'h01 << crs_pkg::FLAG_SUPER)); // RQ16
  end

  // Only the flags answer; PC, A, X and SP have no address
  always_comb begin
    nxt_reg_rdata = crs_pkg::READ_IDLE;
    if (reg_rd && reg_addr == crs_pkg::FLAGS_ADDR) begin
      nxt_reg_rdata = flags_view; // RQ15 RQ13
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= crs_pkg::READ_IDLE;
    end else begin
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

endmodule
`default_nettype wire

//--- verilog/crs_flag_update.sv
// Next value of the user-visible flags after an ALU or flag-logic instruction
`timescale 1ns/100ps
`default_nettype none
module crs_flag_update (
  input  wire logic [7:0] flags_cur,
  input  wire logic       alu_we,
  input  wire logic [7:0] alu_result,
  input  wire logic       alu_carry,
  input  wire logic       upd_zero,
  input  wire logic       upd_carry,
  input  wire logic [1:0] logic_op,
  input  wire logic [7:0] logic_imm,
  output logic      [7:0] flags_nxt
);

  logic [7:0] combined;

  always_comb begin
    combined  = flags_cur;
    flags_nxt = flags_cur;
    // Only the logical instructions on the flags register write it directly
    case (logic_op)
      crs_pkg::CRS_FL_AND: combined = flags_cur & logic_imm; // RQ9
      crs_pkg::CRS_FL_OR:  combined = flags_cur | logic_imm; // RQ9
      crs_pkg::CRS_FL_XOR: combined = flags_cur ^ logic_imm; // RQ9
      default:             combined = flags_cur;
    endcase
    // Supervisory state and reserved bits never change through software
    flags_nxt = (combined & crs_pkg::FLAGS_WMASK) | (flags_cur & ~crs_pkg::FLAGS_WMASK); // RQ16 RQ7
    if (logic_op == crs_pkg::CRS_FL_NONE && alu_we) begin
      if (upd_zero) begin
        flags_nxt[crs_pkg::FLAG_ZERO] = (alu_result == 8'h00); // RQ14 RQ8
      end
      if (upd_carry) begin
        flags_nxt[crs_pkg::FLAG_CARRY] = alu_carry; // RQ11 RQ8
      end
    end
  end

endmodule
`default_nettype wire

//--- verilog/crs_pkg.sv
// Constants and encodings shared by the core register set
package crs_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 16;
  localparam int unsigned PC_MIN_W = 13;
  localparam int unsigned BUS_AW   = 8;
  localparam int unsigned EA_W     = 9;

  // ****************************************
  // Register space
  // ****************************************
  localparam logic [7:0] FLAGS_ADDR  = 8'hf7;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] FLAGS_WMASK = 8'h17;
  localparam logic [7:0] READ_IDLE   = 8'h00;

  // ****************************************
  // Flag bit positions
  // ****************************************
  localparam int unsigned FLAG_GIE   = 0;
  localparam int unsigned FLAG_ZERO  = 1;
  localparam int unsigned FLAG_CARRY = 2;
  localparam int unsigned FLAG_SUPER = 3;
  localparam int unsigned FLAG_BANK  = 4;

  // ****************************************
  // Reset values of the core registers
  // ****************************************
  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic [7:0]  IDX_RESET = 8'h00;
  localparam logic [7:0]  SP_RESET  = 8'h00;
  localparam logic [8:0]  EA_RESET  = 9'h000;

  // ****************************************
  // Stack pointer step sizes, two's complement
  // ****************************************
  localparam logic [7:0] SP_STEP_PUSH  = 8'h01;
  localparam logic [7:0] SP_STEP_POP   = 8'hff;
  localparam logic [7:0] SP_STEP_CALL  = 8'h02;
  localparam logic [7:0] SP_STEP_RET   = 8'hfe;
  localparam logic [7:0] SP_STEP_RETI  = 8'hfd;
  localparam logic [7:0] SP_STEP_NONE  = 8'h00;

  // ****************************************
  // Operation encodings
  // ****************************************
  typedef enum logic [1:0] {
    CRS_PC_HOLD = 2'b00,
    CRS_PC_STEP = 2'b01,
    CRS_PC_LOAD = 2'b10,
    CRS_PC_REL  = 2'b11
  } crs_pc_op_e;

  typedef enum logic [3:0] {
    CRS_SP_NONE  = 4'b0000,
    CRS_SP_PUSH  = 4'b0001,
    CRS_SP_POP   = 4'b0010,
    CRS_SP_CALL  = 4'b0011,
    CRS_SP_LCALL = 4'b0100,
    CRS_SP_RET   = 4'b0101,
    CRS_SP_RETI  = 4'b0110,
    CRS_SP_SWAP  = 4'b0111,
    CRS_SP_ADD   = 4'b1000
  } crs_sp_op_e;

  typedef enum logic [1:0] {
    CRS_FL_NONE = 2'b00,
    CRS_FL_AND  = 2'b01,
    CRS_FL_OR   = 2'b10,
    CRS_FL_XOR  = 2'b11
  } crs_flag_op_e;

endpackage
